// *** dv/hdlc_link_status_chk.sv ***
/* port checker for the link event status block
   bound to hdlc_link_status; one clock, async low reset */
module hdlc_link_status_chk (
    input wire logic        MCLK_I,
    input wire logic        RST_N_I,
    input wire logic        HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic        HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic        HREADYOUT_O,
    input wire logic        HRESP_O,
    input wire logic        TX_BEGIN_I,
    input wire logic        RX_BEGIN_I,
    input wire logic        TX_FINISH_I,
    input wire logic        RX_FINISH_I,
    input wire logic        FCS_FAIL_I,
    input wire logic        IRQ_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tk, rd_st, no_ev, rd_dp, rd_map, en_wr;
    assign tk = HSEL_I && HREADY_I && HTRANS_I == hdlc_link_pkg::HTRANS_NONSEQ;
    assign rd_st = tk && !HWRITE_I && HADDR_I[7:0] == hdlc_link_pkg::STATUS_OFFSET;
    assign no_ev = !(TX_BEGIN_I || RX_BEGIN_I || TX_FINISH_I || RX_FINISH_I || FCS_FAIL_I);
    // remembers the previous transfer so data phases can be judged
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rd_dp  <= 1'b0;
            rd_map <= 1'b0;
            en_wr  <= 1'b0;
        end else begin
            rd_dp  <= tk && !HWRITE_I;
            rd_map <= HADDR_I[7:0] == hdlc_link_pkg::STATUS_OFFSET
                   || HADDR_I[7:0] == hdlc_link_pkg::ENABLE_OFFSET;
            en_wr  <= en_wr || (tk && HWRITE_I && HADDR_I[7:0] == hdlc_link_pkg::ENABLE_OFFSET);
        end
    end
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    // no transfer may clear the flag between the event and the read
    property seen(ev, flag);
        ev && !tk ##1 !tk ##1 rd_st |=> flag;
    endproperty
    ready_high_a: assert property (HREADYOUT_O) else $error("hreadyout low");
    resp_okay_a: assert property (!HRESP_O) else $error("hresp not okay");
    idle_data_a: assert property (!rd_dp |-> HRDATA_O == 32'h0000_0000) else $error("hrdata off phase");
    unmapped_zero_a: assert property (rd_dp && !rd_map |-> HRDATA_O == 32'h0000_0000)
        else $error("unmapped read not zero");
    tx_seen_a: assert property (seen(TX_BEGIN_I, HRDATA_O[6])) else $error("tx begin lost");
    fcs_seen_a: assert property (seen(FCS_FAIL_I, HRDATA_O[2])) else $error("fcs fail lost");
    read_clear_a: assert property (rd_st && no_ev ##1 no_ev [*2] ##1 rd_st && no_ev
        |=> HRDATA_O[6:2] == 5'h00) else $error("flags not cleared by read");
    irq_mask_a: assert property (!en_wr |-> !IRQ_O) else $error("irq while masked");
    reset_zero_a: assert property ($rose(RST_N_I) |-> HRDATA_O == 32'h0000_0000 && !IRQ_O)
        else $error("outputs not zero after reset");
    cover property (rd_st ##1 TX_BEGIN_I);
    cover property (IRQ_O);
    cover property (tk && HWRITE_I);
endmodule : hdlc_link_status_chk

bind hdlc_link_status hdlc_link_status_chk chk (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
    .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
    .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .TX_BEGIN_I(TX_BEGIN_I), .RX_BEGIN_I(RX_BEGIN_I), .TX_FINISH_I(TX_FINISH_I),
    .RX_FINISH_I(RX_FINISH_I), .FCS_FAIL_I(FCS_FAIL_I), .IRQ_O(IRQ_O));

// *** dv/tb_hdlc_link_status.sv ***
/* self-checking bench for hdlc_link_status
   bench is the only ahb-lite master and drives every event input */
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_hdlc_link_status;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ST = hdlc_link_pkg::STATUS_OFFSET;
    localparam logic [7:0] EN = hdlc_link_pkg::ENABLE_OFFSET;
    logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, rbit = 0, rval = 0, done = 0, orient = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0]  htrans = 0;
    logic [4:0]  ev = 0;
    logic        hready, hresp, irq;
    int          fail_count = 0, tests_run = 0;
    always #2 clk = ~clk;
    hdlc_link_status dut (.MCLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .TX_BEGIN_I(ev[4]), .RX_BEGIN_I(ev[3]), .TX_FINISH_I(ev[2]), .RX_FINISH_I(ev[1]),
        .FCS_FAIL_I(ev[0]), .RX_MSG_DONE_I(done), .RX_MSG_ORIENTED_I(orient),
        .RX_BIT_I(rbit), .RX_BIT_VALID_I(rval), .IRQ_O(irq));
    // one single transfer; e is held on the event inputs during the data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, input logic [4:0] e = 5'h00);
        @(posedge clk);
        hsel <= 1; haddr <= {24'h00_0000, a}; hwrite <= w;
        htrans <= hdlc_link_pkg::HTRANS_NONSEQ;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 0; htrans <= hdlc_link_pkg::HTRANS_IDLE; hwdata <= wd; ev <= e;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        ev <= 5'h00;
    endtask : bus
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] d;
        bus(0, a, 32'h0000_0000, d);
        `CHK(nm, e, d)
    endtask : rd_chk
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        bus(1, a, wd, d);
    endtask : wr
    task automatic pulse(input int i);
        @(posedge clk) ev[i] <= 1;
        @(posedge clk) ev[i] <= 0;
        repeat (3) @(posedge clk);
    endtask : pulse
    task automatic sbit(input logic b);
        @(posedge clk) begin rbit <= b; rval <= 1; end
        repeat (4) @(posedge clk);
        rval <= 0;
        repeat (4) @(posedge clk);
    endtask : sbit
    task automatic kind(input logic o);
        @(posedge clk) begin done <= 1; orient <= o; end
        @(posedge clk) done <= 0;
        repeat (3) @(posedge clk);
    endtask : kind
    task automatic t_reset;
        rd_chk(ST, 32'h0000_0000, "status");
        rd_chk(EN, 32'h0000_0000, "enable");
        rd_chk(8'h0C, 32'h0000_0000, "unmapped");
    endtask : t_reset
    task automatic t_events;
        for (int i = 0; i < 5; i++) begin
            pulse(4 - i);
            rd_chk(ST, 32'h0000_0040 >> i, "event flag");
            rd_chk(ST, 32'h0000_0000, "after read");
        end
    endtask : t_events
    task automatic t_kind;
        kind(1);
        rd_chk(ST, 32'h0000_0080, "kind one");
        wr(ST, 32'h0000_0080);
        rd_chk(ST, 32'h0000_0080, "kind kept");
        kind(0);
        rd_chk(ST, 32'h0000_0000, "kind zero");
    endtask : t_kind
    task automatic t_serial;
        // a zero, then seven ones
        for (int i = 7; i >= 0; i--) sbit(i != 7);
        repeat (6) @(posedge clk);
        rd_chk(ST, 32'h0000_0002, "abort");
        for (int i = 7; i >= 0; i--) sbit(hdlc_link_pkg::FLAG_OCTET[i]);
        repeat (6) @(posedge clk);
        rd_chk(ST, 32'h0000_0001, "flag octet");
    endtask : t_serial
    task automatic t_irq;
        wr(EN, 32'h0000_0040);
        rd_chk(EN, 32'h0000_0040, "enable");
        pulse(0);
        `CHK("irq masked", 1'b0, irq)
        pulse(4);
        `CHK("irq raised", 1'b1, irq)
        rd_chk(ST, 32'h0000_0044, "status");
        repeat (2) @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
    endtask : t_irq
    task automatic t_collide;
        logic [31:0] d;
        bus(0, ST, 32'h0000_0000, d, 5'h11);
        `CHK("clearing read", 32'h0000_0000, d)
        rd_chk(ST, 32'h0000_0044, "kept flags");
    endtask : t_collide
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        t_reset();
        t_events();
        t_kind();
        t_serial();
        t_irq();
        t_collide();
        end_of_test();
    end
endmodule : tb_hdlc_link_status

// *** pkg/hdlc_link_pkg.sv ***
/*
 * constants for the hdlc link event status block: register offsets,
 * bit positions, reset values and ahb-lite encodings.
 * assumes a single 32-bit ahb-lite slave port, word accesses only.
 */
package hdlc_link_pkg;

    // register byte offsets
    localparam logic [7:0] STATUS_OFFSET  = 8'h00;
    localparam logic [7:0] ENABLE_OFFSET  = 8'h04;
    localparam logic [7:0] MSGKIND_OFFSET = 8'h08;

    // status bit positions
    localparam int MSG_KIND_BIT  = 7;
    localparam int TX_BEGIN_BIT  = 6;
    localparam int RX_BEGIN_BIT  = 5;
    localparam int TX_FINISH_BIT = 4;
    localparam int RX_FINISH_BIT = 3;
    localparam int FCS_FAIL_BIT  = 2;
    localparam int ABORT_BIT     = 1;
    localparam int IDLE_BIT      = 0;
    localparam int EVENT_COUNT   = 7;

    // reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [6:0] ENABLE_RESET = 7'h00;

    // abort is seven ones, idle is the flag octet
    localparam int         ABORT_ONES   = 7;
    localparam logic [7:0] FLAG_OCTET   = 8'h7E;

    // ahb-lite htrans codes
    localparam logic [1:0] HTRANS_IDLE   = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : hdlc_link_pkg

// *** src/hdlc_link_status.sv ***
/*
 * hdlc link event status register with interrupt enable, ahb-lite slave.
 * event inputs come from hdlc controllers on the same clock as one-cycle
 * pulses; the serial receive bit and its valid come from a pin and are
 * synchronised here before the abort and flag octet detectors.
 */
module hdlc_link_status (
    input  wire logic        MCLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    input  wire logic        TX_BEGIN_I,
    input  wire logic        RX_BEGIN_I,
    input  wire logic        TX_FINISH_I,
    input  wire logic        RX_FINISH_I,
    input  wire logic        FCS_FAIL_I,
    input  wire logic        RX_MSG_DONE_I,
    input  wire logic        RX_MSG_ORIENTED_I,
    input  wire logic        RX_BIT_I,
    input  wire logic        RX_BIT_VALID_I,
    output logic             IRQ_O
);

    // serial input synchronisers
    logic [1:0] bit_sync_reg;
    logic [1:0] bit_sync_next;
    logic [1:0] vld_sync_reg;
    logic [1:0] vld_sync_next;
    logic       vld_prev_reg;
    logic       vld_prev_next;

    // receive pattern detector
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [2:0] ones_reg;
    logic [2:0] ones_next;
    logic       abort_evt;
    logic       idle_evt;
    logic       bit_strobe;

    // bus and register state
    logic       msg_kind_reg;
    logic       msg_kind_next;
    logic [6:0] enable_reg;
    logic [6:0] enable_next;
    logic       dphase_reg;
    logic       dphase_next;
    logic       dwrite_reg;
    logic       dwrite_next;
    logic [7:0] daddr_reg;
    logic [7:0] daddr_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic       irq_reg;
    logic       irq_next;
    logic       ready_reg;
    logic       ready_next;
    logic       resp_reg;
    logic       resp_next;

    logic       addr_take;
    logic       read_status;
    logic       wr_status;
    logic       wr_enable;
    logic [6:0] events;
    logic [6:0] clears;
    logic [6:0] flags;

    // a transfer is taken only when the bus is ready and the slave selected
    assign addr_take = HSEL_I && HREADY_I && (HTRANS_I == hdlc_link_pkg::HTRANS_NONSEQ);
    // one bit per rising edge of the synchronised valid
    assign bit_strobe = vld_sync_reg[1] && !vld_prev_reg;

    // two-flop synchronisers for the serial pins
    always_comb begin
        bit_sync_next = {bit_sync_reg[0], RX_BIT_I};
        vld_sync_next = {vld_sync_reg[0], RX_BIT_VALID_I};
        vld_prev_next = vld_sync_reg[1];
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            bit_sync_reg <= 2'h0;
            vld_sync_reg <= 2'h0;
            vld_prev_reg <= 1'b0;
        end else begin
            bit_sync_reg <= bit_sync_next;
            vld_sync_reg <= vld_sync_next;
            vld_prev_reg <= vld_prev_next;
        end
    end

    // abort and flag octet detectors, one step per received bit
    always_comb begin
        shift_next = shift_reg;
        ones_next  = ones_reg;
        abort_evt  = 1'b0;
        idle_evt   = 1'b0;
        if (bit_strobe) begin
            shift_next = {shift_reg[6:0], bit_sync_reg[1]};
            if (bit_sync_reg[1]) begin
                if (ones_reg == 3'(hdlc_link_pkg::ABORT_ONES - 1)) begin
                    abort_evt = 1'b1;
                end
                // saturate so a long run of ones fires only once
                if (ones_reg != 3'(hdlc_link_pkg::ABORT_ONES)) begin
                    ones_next = ones_reg + 3'h1;
                end
            end else begin
                ones_next = 3'h0;
            end
            idle_evt = ({shift_reg[6:0], bit_sync_reg[1]} == hdlc_link_pkg::FLAG_OCTET);
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            shift_reg <= 8'h00;
            ones_reg  <= 3'h0;
        end else begin
            shift_reg <= shift_next;
            ones_reg  <= ones_next;
        end
    end

    always_comb begin
        events = 7'h00;
        events[hdlc_link_pkg::TX_BEGIN_BIT]  = TX_BEGIN_I;
        events[hdlc_link_pkg::RX_BEGIN_BIT]  = RX_BEGIN_I;
        events[hdlc_link_pkg::TX_FINISH_BIT] = TX_FINISH_I;
        events[hdlc_link_pkg::RX_FINISH_BIT] = RX_FINISH_I;
        events[hdlc_link_pkg::FCS_FAIL_BIT]  = FCS_FAIL_I;
        events[hdlc_link_pkg::ABORT_BIT]     = abort_evt;
        events[hdlc_link_pkg::IDLE_BIT]      = idle_evt;
    end

    // data phase decode of the transfer taken one cycle earlier
    always_comb begin
        read_status = 1'b0;
        wr_status   = 1'b0;
        wr_enable   = 1'b0;
        if (dphase_reg) begin
            case (daddr_reg)
                hdlc_link_pkg::STATUS_OFFSET: begin
                    read_status = !dwrite_reg;
                    wr_status   = dwrite_reg;
                end
                hdlc_link_pkg::ENABLE_OFFSET: begin
                    wr_enable = dwrite_reg;
                end
                default: begin
                    read_status = 1'b0;
                end
            endcase
        end
    end

    // clear on read, or write one to clear
    always_comb begin
        clears = 7'h00;
        if (read_status) begin
            // only the flags this read returned; a later event is kept
            clears = rdata_reg[6:0];
        end else if (wr_status) begin
            clears = HWDATA_I[6:0];
        end
    end

    // one sticky flag per event bit, set wins inside each
    genvar g;
    generate
        for (g = 0; g < hdlc_link_pkg::EVENT_COUNT; g++) begin : gen_flag
            hdlc_sticky_bit u_flag (
                .clk_i   (MCLK_I),
                .rst_n_i (RST_N_I),
                .event_i (events[g]),
                .clear_i (clears[g]),
                .flag_o  (flags[g])
            );
        end
    endgenerate

    // bus phase group: carries the address phase into the data phase
    always_comb begin
        dphase_next = addr_take;
        dwrite_next = dwrite_reg;
        daddr_next  = daddr_reg;
        rdata_next  = 32'h0000_0000;
        if (addr_take) begin
            dwrite_next = HWRITE_I;
            daddr_next  = {HADDR_I[7:2], 2'h0};
            if (!HWRITE_I) begin
                case ({HADDR_I[7:2], 2'h0})
                    hdlc_link_pkg::STATUS_OFFSET: begin
                        // flags cleared this cycle, by the previous read or a write of one, read as zero
                        rdata_next = {24'h00_0000, msg_kind_reg, flags & ~clears};
                    end
                    hdlc_link_pkg::ENABLE_OFFSET: begin
                        rdata_next = {25'h000_0000, enable_reg};
                    end
                    default: begin
                        rdata_next = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            dphase_reg <= 1'b0;
            dwrite_reg <= 1'b0;
            daddr_reg  <= 8'h00;
            rdata_reg  <= 32'h0000_0000;
        end else begin
            dphase_reg <= dphase_next;
            dwrite_reg <= dwrite_next;
            daddr_reg  <= daddr_next;
            rdata_reg  <= rdata_next;
        end
    end

    // register group: message kind and interrupt enables
    always_comb begin
        msg_kind_next = msg_kind_reg;
        enable_next   = enable_reg;
        // kind latched from the receiver only, bus writes ignored
        if (RX_MSG_DONE_I) begin
            msg_kind_next = RX_MSG_ORIENTED_I;
        end
        // enables take effect at the end of the write data phase
        if (wr_enable) begin
            enable_next = HWDATA_I[6:0];
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            msg_kind_reg <= hdlc_link_pkg::STATUS_RESET[hdlc_link_pkg::MSG_KIND_BIT];
            enable_reg   <= hdlc_link_pkg::ENABLE_RESET;
        end else begin
            msg_kind_reg <= msg_kind_next;
            enable_reg   <= enable_next;
        end
    end

    // output group: every port comes straight from a flop
    always_comb begin
        irq_next   = |(flags & enable_reg);
        // zero wait states and always okay
        ready_next = 1'b1;
        resp_next  = 1'b0;
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_reg   <= 1'b0;
            ready_reg <= 1'b1;
            resp_reg  <= 1'b0;
        end else begin
            irq_reg   <= irq_next;
            ready_reg <= ready_next;
            resp_reg  <= resp_next;
        end
    end

    assign HRDATA_O    = rdata_reg;
    assign HREADYOUT_O = ready_reg;
    assign HRESP_O     = resp_reg;
    assign IRQ_O       = irq_reg;

endmodule : hdlc_link_status

// *** src/hdlc_sticky_bit.sv ***
/*
 * one sticky event flag: set by a hardware event, cleared by a
 * clearing read or a write of one. set wins over clear.
 * assumes all inputs are on the same clock as the flag.
 */
module hdlc_sticky_bit (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic event_i,
    input  wire logic clear_i,
    output logic      flag_o
);

    logic flag_reg;
    logic flag_next;

    always_comb begin
        flag_next = flag_reg;
        if (clear_i) begin
            flag_next = 1'b0;
        end
        if (event_i) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag_o = flag_reg;

endmodule : hdlc_sticky_bit
